//--- design/itk_pkg.sv
// Package with register map, field layout and timing constants of the interval timekeeper.
package itk_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_INTERVAL_CONTROL = 8'hA1;
  localparam logic [7:0] ADDR_SUBSECOND_TIME   = 8'hA2;
  localparam logic [7:0] ADDR_SECOND_TIME      = 8'hA3;
  localparam logic [7:0] ADDR_MINUTE_TIME      = 8'hA4;
  localparam logic [7:0] ADDR_HOUR_TIME        = 8'hA5;
  localparam logic [7:0] ADDR_INTERVAL_TARGET  = 8'hA6;

  // Bit positions inside interval_control.
  localparam int BIT_UNUSED     = 7;
  localparam int BIT_HOUR_FMT   = 6;
  localparam int BIT_BASE_HI    = 5;
  localparam int BIT_BASE_LO    = 4;
  localparam int BIT_SINGLE     = 3;
  localparam int BIT_FLAG       = 2;
  localparam int BIT_INT_ENABLE = 1;
  localparam int BIT_TIME_EN    = 0;

  // Reset values.
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIME    = 8'h00;
  localparam logic [7:0] RST_TARGET  = 8'h00;

  // Interval timebase encodings.
  localparam logic [1:0] BASE_SUBSEC = 2'b00;
  localparam logic [1:0] BASE_SEC    = 2'b01;
  localparam logic [1:0] BASE_MIN    = 2'b10;
  localparam logic [1:0] BASE_HOUR   = 2'b11;

  // Counter limits.
  localparam logic [7:0] LIM_SUBSEC  = 8'h7F;
  localparam logic [7:0] LIM_SEC_MIN = 8'h3B;
  localparam logic [7:0] LIM_HOUR24  = 8'h17;
  localparam logic [7:0] LIM_HOUR256 = 8'hFF;

  // Crystal rate and the subsecond tick rate give the prescaler length.
  localparam int         XTAL_HZ    = 32768;
  localparam int         SUBSEC_HZ  = 128;
  localparam logic [7:0] PRESC_LAST = 8'((XTAL_HZ / SUBSEC_HZ) - 1);

  // Steps a time count; carry is set when the count passes its limit and wraps.
  function automatic logic [8:0] itk_step(input logic [7:0] v, input logic [7:0] lim);
    logic [8:0] r;
    r = {1'b0, v + 8'h01};
    if (v >= lim)
    begin
      r = {1'b1, 8'h00};
    end
    return r;
  endfunction

endpackage

//--- design/itk_tick_if.sv
// Interface carrying the subsecond tick and the run level between the two modules.
`timescale 1ns/100ps
`default_nettype none
interface itk_tick_if;
  logic tick;
  logic run;
  modport gen (output tick, input run);
  modport sink (input tick, output run);
endinterface
`default_nettype wire

//--- design/itk_tick_gen.sv
// Crystal synchroniser and prescaler producing the 1/128 second tick.
`timescale 1ns/100ps
`default_nettype none
module itk_tick_gen
  import itk_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic xtal_i,
  itk_tick_if.gen   tif
);

  typedef struct packed {
    logic       xs1;
    logic       xs2;
    logic       xprev;
    logic [7:0] presc;
    logic       tick;
  } itk_gen_st_t;

  itk_gen_st_t s;
  itk_gen_st_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // The crystal pin passes two flops; only the second one feeds the edge detect.
  always_comb
  begin
    next_s       = s;
    next_s.xs1   = xtal_i;
    next_s.xs2   = s.xs1;
    next_s.xprev = s.xs2;
    next_s.tick  = 1'b0;
    // Prescaler is held at zero while stopped so a restart begins a full tick.
    if (!tif.run)
    begin
      next_s.presc = 8'h00;
    end
    else if (s.xs2 && !s.xprev)
    begin
      if (s.presc == PRESC_LAST)
      begin
        next_s.presc = 8'h00;
        next_s.tick  = 1'b1;
      end
      else
      begin
        next_s.presc = s.presc + 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tif.tick = s.tick;

  ////////////////////////////////////////////////////////////////////////////
  // A tick only follows a synchronised rising crystal edge.
  property p_tick_edge;
    @(posedge clk_i) disable iff (srst_i)
    s.tick |-> $past(s.xs2) && !$past(s.xprev);
  endproperty
  a_tick_edge: assert property (p_tick_edge) else $error("tick without crystal edge");

  // No tick while timekeeping is stopped.
  property p_no_tick_stopped;
    @(posedge clk_i) disable iff (srst_i)
    !tif.run |=> !s.tick;
  endproperty
  a_no_tick_stopped: assert property (p_no_tick_stopped) else $error("tick while stopped");

endmodule
`default_nettype wire

//--- design/itk_top.sv
// Interval timekeeper: time registers, interval counter and register port.
`timescale 1ns/100ps
`default_nettype none
module itk_top
  import itk_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       xtal_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       int_en_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            irq_o
);

  typedef struct packed {
    logic       hour_format_select;
    logic [1:0] interval_base_select;
    logic       single_shot;
    logic       interval_flag;
    logic       interval_enable;
    logic       timekeeping_enable;
    logic [7:0] sub;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] sh_sub;
    logic [7:0] sh_sec;
    logic [7:0] sh_min;
    logic [7:0] sh_hour;
    logic [7:0] target;
    logic [7:0] icnt;
    logic [7:0] rdata;
  } itk_st_t;

  itk_st_t    s;
  itk_st_t    next_s;
  itk_tick_if tif ();

  logic       tick;
  logic [8:0] st_sub;
  logic [8:0] st_sec;
  logic [8:0] st_min;
  logic [8:0] st_hour;
  logic       c_sub;
  logic       c_sec;
  logic       c_min;
  logic       advance;
  logic       match;
  logic       wr_ctl;
  logic       wr_time;

  ////////////////////////////////////////////////////////////////////////////
  // The crystal tick comes from the prescaler module in the same clock domain.
  itk_tick_gen u_tick
  (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .xtal_i (xtal_i),
    .tif    (tif.gen)
  );

  assign tif.run = s.timekeeping_enable;
  assign tick    = tif.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Time chain steps; carries ripple only on a tick while timekeeping runs.
  always_comb
  begin
    st_sub  = itk_step(s.sub, LIM_SUBSEC);
    st_sec  = itk_step(s.sec, LIM_SEC_MIN);
    st_min  = itk_step(s.min, LIM_SEC_MIN);
    st_hour = itk_step(s.hour, s.hour_format_select ? LIM_HOUR24 : LIM_HOUR256);
    c_sub   = tick && s.timekeeping_enable && st_sub[8];
    c_sec   = c_sub && st_sec[8];
    c_min   = c_sec && st_min[8];
  end

  // The interval counter steps whenever the selected time register steps while interval_enable is set.
  always_comb
  begin
    case (s.interval_base_select)
      BASE_SUBSEC: advance = tick && s.timekeeping_enable;
      BASE_SEC:    advance = c_sub;
      BASE_MIN:    advance = c_sec;
      BASE_HOUR:   advance = c_min;
      default:     advance = 1'b0;
    endcase
    advance = advance && s.interval_enable;
    match   = advance && ((s.icnt + 8'h01) == s.target);
  end

  assign wr_ctl  = sfr_wr_i && (sfr_addr_i == ADDR_INTERVAL_CONTROL);
  assign wr_time = sfr_wr_i && !s.timekeeping_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Software writes land first; hardware events then override them,
  // so a flag set in the same cycle as a clearing write is kept.
  always_comb
  begin
    next_s = s;

    // Control register; bit 7 has no storage and is dropped.
    if (wr_ctl)
    begin
      next_s.hour_format_select   = sfr_wdata_i[BIT_HOUR_FMT];
      next_s.interval_base_select = sfr_wdata_i[BIT_BASE_HI:BIT_BASE_LO];
      next_s.single_shot          = sfr_wdata_i[BIT_SINGLE];
      next_s.interval_flag        = sfr_wdata_i[BIT_FLAG];
      next_s.interval_enable      = sfr_wdata_i[BIT_INT_ENABLE];
      next_s.timekeeping_enable   = sfr_wdata_i[BIT_TIME_EN];
    end
    if (sfr_wr_i && (sfr_addr_i == ADDR_INTERVAL_TARGET))
    begin
      next_s.target = sfr_wdata_i;
    end

    // Time registers are loaded only while stopped; a write while running is dropped.
    if (wr_time)
    begin
      case (sfr_addr_i)
        ADDR_SUBSECOND_TIME: next_s.sh_sub  = sfr_wdata_i;
        ADDR_SECOND_TIME:    next_s.sh_sec  = sfr_wdata_i;
        ADDR_MINUTE_TIME:    next_s.sh_min  = sfr_wdata_i;
        ADDR_HOUR_TIME:      next_s.sh_hour = sfr_wdata_i;
        default:             next_s.sh_sub  = next_s.sh_sub;
      endcase
    end

    if (!s.timekeeping_enable)
    begin
      // Stopped: live time follows the written values and the interval restarts.
      next_s.sub  = next_s.sh_sub;
      next_s.sec  = next_s.sh_sec;
      next_s.min  = next_s.sh_min;
      next_s.hour = next_s.sh_hour;
      next_s.icnt = 8'h00;
    end
    else if (tick)
    begin
      next_s.sub = st_sub[7:0];
      if (c_sub)
      begin
        next_s.sec = st_sec[7:0];
      end
      if (c_sec)
      begin
        next_s.min = st_min[7:0];
      end
      if (c_min)
      begin
        next_s.hour = st_hour[7:0];
      end
    end

    // Interval counter and timeout.
    if (s.timekeeping_enable && advance)
    begin
      if (match)
      begin
        next_s.icnt          = 8'h00;
        next_s.interval_flag = 1'b1;
        if (s.single_shot)
        begin
          next_s.interval_enable = 1'b0;
        end
      end
      else
      begin
        next_s.icnt = s.icnt + 8'h01;
      end
    end

    // Read data is captured on the read strobe; unmapped addresses read zero.
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        ADDR_INTERVAL_CONTROL: next_s.rdata = {1'b0, s.hour_format_select,
                                               s.interval_base_select, s.single_shot,
                                               s.interval_flag, s.interval_enable,
                                               s.timekeeping_enable};
        ADDR_SUBSECOND_TIME:   next_s.rdata = s.sub;
        ADDR_SECOND_TIME:      next_s.rdata = s.sec;
        ADDR_MINUTE_TIME:      next_s.rdata = s.min;
        ADDR_HOUR_TIME:        next_s.rdata = s.hour;
        ADDR_INTERVAL_TARGET:  next_s.rdata = s.target;
        default:               next_s.rdata = 8'h00;
      endcase
    end
  end

  // State register; every field resets to zero.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sfr_rdata_o = s.rdata;
  // The core's enable for this source gates the sticky flag.
  assign irq_o       = s.interval_flag && int_en_i;

  ////////////////////////////////////////////////////////////////////////////
  // Control bit 7 always reads back as zero.
  property p_bit7_zero;
    @(posedge clk_i) disable iff (srst_i)
    sfr_rd_i && (sfr_addr_i == ADDR_INTERVAL_CONTROL) |=> !sfr_rdata_o[BIT_UNUSED];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 reads one");

  // In 24 hour format hour 23 wraps to zero on an hour carry.
  property p_hour24_wrap;
    @(posedge clk_i) disable iff (srst_i)
    c_min && s.hour_format_select && (s.hour == LIM_HOUR24) |=> (s.hour == 8'h00);
  endproperty
  a_hour24_wrap: assert property (p_hour24_wrap) else $error("hour did not wrap at 23");

  // With seconds selected, the interval count holds between subsecond rollovers.
  property p_base_sec;
    @(posedge clk_i) disable iff (srst_i)
    s.timekeeping_enable && (s.interval_base_select == BASE_SEC) && !c_sub
      |=> $stable(s.icnt);
  endproperty
  a_base_sec: assert property (p_base_sec) else $error("interval moved off base");

  // A single-shot timeout clears the enable and sets the flag.
  property p_single_shot;
    @(posedge clk_i) disable iff (srst_i)
    match && s.single_shot |=> !s.interval_enable && s.interval_flag;
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("single shot kept running");

  // A timeout zeroes the interval counter; auto reload keeps it enabled.
  property p_reload;
    @(posedge clk_i) disable iff (srst_i)
    match && !s.single_shot && !wr_ctl |=> (s.icnt == 8'h00) && s.interval_enable;
  endproperty
  a_reload: assert property (p_reload) else $error("interval did not reload");

  // A timeout sets the flag, which shows on the interrupt output only when enabled.
  property p_irq;
    @(posedge clk_i) disable iff (srst_i)
    match |=> (irq_o == int_en_i);
  endproperty
  a_irq: assert property (p_irq) else $error("flag did not raise interrupt");

  // The interval counter is frozen while timekeeping runs with interval counting disabled.
  property p_gate;
    @(posedge clk_i) disable iff (srst_i)
    s.timekeeping_enable && !s.interval_enable |=> $stable(s.icnt);
  endproperty
  a_gate: assert property (p_gate) else $error("interval counted while disabled");

  // One cycle after stopping, live time equals the written values.
  property p_restore;
    @(posedge clk_i) disable iff (srst_i)
    !s.timekeeping_enable ##1 !s.timekeeping_enable
      |-> (s.sub == s.sh_sub) && (s.sec == s.sh_sec) && (s.min == s.sh_min)
          && (s.hour == s.sh_hour);
  endproperty
  a_restore: assert property (p_restore) else $error("time not restored");

  // Subsecond rolls 127 to 0 and advances seconds.
  property p_sub_wrap;
    @(posedge clk_i) disable iff (srst_i)
    tick && s.timekeeping_enable && (s.sub == LIM_SUBSEC)
      |=> (s.sub == 8'h00) && (s.sec != $past(s.sec));
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("subsecond wrap wrong");

  // Target clears on reset.
  property p_target_rst;
    @(posedge clk_i)
    srst_i |=> (s.target == RST_TARGET);
  endproperty
  a_target_rst: assert property (p_target_rst) else $error("target not reset");

endmodule
`default_nettype wire

//--- verif/test_itk_top.sv
// Self-checking testbench of the interval timekeeper with a behavioural register model.
`timescale 1ns/100ps
`default_nettype none
module test_itk_top
  import itk_pkg::*;
;
  logic        clk_i;
  logic        srst_i;
  logic        xtal_i;
  logic [7:0]  sfr_addr_i;
  logic        sfr_wr_i;
  logic        sfr_rd_i;
  logic [7:0]  sfr_wdata_i;
  logic        int_en_i;
  logic [7:0]  sfr_rdata_o;
  logic        irq_o;
  int          num_errors;
  int          samples_checked;
  int          cycles;
  logic [31:0] lfsr;
  // Model state: control, target, hidden interval count, live and last written time values.
  int          m_ctl;
  int          m_tgt;
  int          m_icnt;
  int          m_t[4];
  int          w_t[4];

  itk_top itk_top_i (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .xtal_i      (xtal_i),
    .sfr_addr_i  (sfr_addr_i),
    .sfr_wr_i    (sfr_wr_i),
    .sfr_rd_i    (sfr_rd_i),
    .sfr_wdata_i (sfr_wdata_i),
    .int_en_i    (int_en_i),
    .sfr_rdata_o (sfr_rdata_o),
    .irq_o       (irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; about 20 ticks of 1024 cycles fit well under the ceiling.
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  // One write strobe; the model follows the register rules.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2 sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #2 sfr_wr_i = 1'b0;
    if (a == ADDR_INTERVAL_CONTROL)
    begin
      m_ctl = int'(d & 8'h7f);
      if (m_ctl[0] == 0)
      begin
        m_t = w_t;
        m_icnt = 0;
      end
    end
    else if (a >= ADDR_SUBSECOND_TIME && a <= ADDR_HOUR_TIME && m_ctl[0] == 0)
    begin
      m_t[a - ADDR_SUBSECOND_TIME] = d;
      w_t[a - ADDR_SUBSECOND_TIME] = d;
    end
    else if (a == ADDR_INTERVAL_TARGET)
      m_tgt = d;
  endtask

  // Read data is taken just after the edge that samples the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #2 sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge clk_i);
    #2 sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask

  // Loads subsecond, second, minute and hour from the low byte up.
  task automatic load(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      wr(ADDR_SUBSECOND_TIME + 8'(i), v[8*i +: 8]);
  endtask

  // Sends 256 crystal rises, one 1/128 second tick, then steps the model.
  task automatic tick();
    int c;
    int lim;
    int adv;
    repeat (256)
    begin
      @(posedge clk_i);
      #2 xtal_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #2 xtal_i = 1'b0;
      @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    if (m_ctl[0] == 1)
    begin
      c = 1;
      adv = 0;
      for (int i = 0; i < 4; i++)
      begin
        if (m_ctl[5:4] == i)
          adv = c;
        lim = (i == 0) ? 127 : (i < 3) ? 59 : (m_ctl[6] ? 23 : 255);
        if (c == 1)
        begin
          if (m_t[i] >= lim)
            m_t[i] = 0;
          else
          begin
            m_t[i]++;
            c = 0;
          end
        end
      end
      if (adv == 1 && m_ctl[1] == 1)
      begin
        m_icnt = (m_icnt + 1) % 256;
        if (m_icnt == m_tgt)
        begin
          m_icnt = 0;
          m_ctl[2] = 1;
          if (m_ctl[3] == 1)
            m_ctl[1] = 0;
        end
      end
    end
  endtask

  // Reads every register and checks the interrupt under a random source enable.
  task automatic cmp_all();
    logic [7:0] d;
    rd(ADDR_INTERVAL_CONTROL, d);
    chk8("control", 8'(m_ctl), d);
    for (int i = 0; i < 4; i++)
    begin
      rd(ADDR_SUBSECOND_TIME + 8'(i), d);
      chk8("time", 8'(m_t[i]), d);
    end
    rd(ADDR_INTERVAL_TARGET, d);
    chk8("target", 8'(m_tgt), d);
    rd(8'ha0, d);
    chk8("unmapped", 8'h00, d);
    @(posedge clk_i);
    #2 int_en_i = lfsr[3];
    lfsr = lfsr_next(lfsr);
    #5 chk1("irq", m_ctl[2] == 1 && int_en_i, irq_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [31:0] v;
    srst_i = 1'b1;
    xtal_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_wdata_i = 8'h00;
    int_en_i = 1'b0;
    lfsr = 32'hf74a_4538;
    m_ctl = 0;
    m_tgt = 0;
    m_icnt = 0;
    m_t = '{0, 0, 0, 0};
    w_t = '{0, 0, 0, 0};
    repeat (12) @(posedge clk_i);
    #2 srst_i = 1'b0;
    cmp_all();
    // Random control bits with the unused top bit set, then an unmapped write.
    wr(ADDR_INTERVAL_CONTROL, {1'b1, lfsr[6:1], 1'b0});
    wr(8'ha7, lfsr[15:8]);
    cmp_all();
    // Full ripple in 24 hour mode with a two-tick interval.
    wr(ADDR_INTERVAL_CONTROL, 8'h00);
    load(32'h173b_3b7e);
    wr(ADDR_INTERVAL_TARGET, 8'h02);
    wr(ADDR_INTERVAL_CONTROL, 8'h43);
    cmp_all();
    tick();
    cmp_all();
    tick();
    cmp_all();
    wr(ADDR_HOUR_TIME, 8'h05);
    cmp_all();
    wr(ADDR_INTERVAL_CONTROL, 8'h40);
    cmp_all();
    tick();
    cmp_all();
    // Hour counts past 23 and wraps after 255 with the select bit clear.
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_INTERVAL_CONTROL, 8'h00);
      load(i == 0 ? 32'h173b_3b7f : 32'hff3b_3b7f);
      wr(ADDR_INTERVAL_CONTROL, 8'h01);
      tick();
      cmp_all();
    end
    // Single shot stops the interval; with the enable gone no new flag appears.
    wr(ADDR_INTERVAL_CONTROL, 8'h00);
    load(32'h0000_0000);
    wr(ADDR_INTERVAL_TARGET, 8'h01);
    wr(ADDR_INTERVAL_CONTROL, 8'h0b);
    tick();
    cmp_all();
    wr(ADDR_INTERVAL_CONTROL, 8'h09);
    tick();
    cmp_all();
    // Auto reload gives a timeout every second tick.
    wr(ADDR_INTERVAL_CONTROL, 8'h00);
    wr(ADDR_INTERVAL_TARGET, 8'h02);
    wr(ADDR_INTERVAL_CONTROL, 8'h03);
    repeat (2)
    begin
      repeat (2)
      begin
        tick();
        cmp_all();
      end
      wr(ADDR_INTERVAL_CONTROL, 8'h03);
    end
    // Each timebase fires only when its own register steps.
    for (int b = 0; b < 4; b++)
      for (int n = 0; n < 2; n++)
        if (b > 0 || n == 0)
        begin
          v = 32'h173b_3b7f & ~(32'hffff_ffff << (8 * (b - n)));
          wr(ADDR_INTERVAL_CONTROL, 8'h00);
          load(v);
          wr(ADDR_INTERVAL_TARGET, 8'h01);
          wr(ADDR_INTERVAL_CONTROL, 8'h43 | 8'(b << 4));
          tick();
          cmp_all();
        end
    // A second reset in mid-run returns every register to zero.
    @(posedge clk_i);
    #2 srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #2 srst_i = 1'b0;
    m_ctl = 0;
    m_tgt = 0;
    m_icnt = 0;
    m_t = '{0, 0, 0, 0};
    w_t = '{0, 0, 0, 0};
    cmp_all();
    finish_test();
  end
endmodule
`default_nettype wire
